// File: src/packet_fifo_level_tracking.sv
// The APB register port was left to the implementer.
`timescale 1ns/1ps
// What this block does
// - Wait programmed delay before any short packet
// - Delay field resets to 800h, upper reserved
// - Rx read level adds packet; minus per read
// - Rx read rewind restores DWORDs already read
// - Usb error rewinds rx read to packet start
// - Rx write level plus per write; packet subtract
// - Frame check error drops partial rx write
// - Tx read level adds packet; minus per read
// - Tx read side never rewinds
// - Tx write level plus per write; packet subtract
// - Bad host packet rewound out of tx
// - Rx read pointer visible read only
// - Rx write pointer visible read only
module packet_fifo_level_tracking
  import pkt_fifo_pkg::*;
#(
  parameter int RX_DEPTH = 8192,
  parameter int TX_DEPTH = 2048
) (
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire fifo_evt_t         i_rx_evt,
  input  wire fifo_evt_t         i_tx_evt,
  input  wire logic              i_short_req,
  output logic                   o_short_go
);

  // ****************************************************************
  // Derived constants
  // ****************************************************************
  localparam logic [RX_PTR_W-1:0] RX_LAST = RX_PTR_W'(RX_DEPTH - 1);
  localparam int TICKS_NUM = DELAY_UNIT_PS;
  localparam int TICKS_DEN = CLK_PERIOD_PS;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [DELAY_W-1:0]  delay;
    logic [RX_LVL_W-1:0] rx_rd_lvl;
    logic [RX_LVL_W-1:0] rx_wr_lvl;
    logic [RX_LVL_W-1:0] rx_rd_cnt;  // DWORDs read of current packet
    logic [RX_LVL_W-1:0] rx_wr_cnt;  // DWORDs written of current packet
    logic [RX_PTR_W-1:0] rx_rd_ptr;
    logic [RX_PTR_W-1:0] rx_wr_ptr;
    logic [RX_PTR_W-1:0] rx_rd_start;
    logic [RX_PTR_W-1:0] rx_wr_start;
    logic [TX_LVL_W-1:0] tx_rd_lvl;
    logic [TX_LVL_W-1:0] tx_wr_lvl;
    logic [TX_LVL_W-1:0] tx_rd_cnt;
    logic [TX_LVL_W-1:0] tx_wr_cnt;
    logic [TX_PTR_W-1:0] tx_rd_ptr;
    logic [TX_PTR_W-1:0] tx_wr_ptr;
    logic [TX_PTR_W-1:0] tx_wr_start;
    sp_state_t           sp;
    logic [31:0]         sp_acc;     // Elapsed time in picoseconds
    logic [31:0]         prdata;
    logic                pready;
    logic                short_go;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Pointer step with wrap at depth
  function automatic logic [RX_PTR_W-1:0] rx_inc(input logic [RX_PTR_W-1:0] p);
    rx_inc = (p == RX_LAST) ? '0 : p + 1'b1;
  endfunction : rx_inc

  function automatic logic [TX_PTR_W-1:0] tx_inc(input logic [TX_PTR_W-1:0] p);
    tx_inc = (p == TX_PTR_W'(TX_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : tx_inc

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic                rd_cyc;
    logic [RX_LVL_W-1:0] rx_wr_pkt;
    logic [RX_LVL_W-1:0] rx_rd_pkt;
    logic [TX_LVL_W-1:0] tx_wr_pkt;
    logic [TX_LVL_W-1:0] tx_rd_pkt;
    rd_cyc    = 1'b0;
    rx_wr_pkt = '0;
    rx_rd_pkt = '0;
    tx_wr_pkt = '0;
    tx_rd_pkt = '0;
    s_d       = s_q;

    // Rx write side
    if (i_rx_evt.wr_rewind) begin
      s_d.rx_wr_lvl = s_q.rx_wr_lvl - s_q.rx_wr_cnt;
      s_d.rx_wr_ptr = s_q.rx_wr_start;
      s_d.rx_wr_cnt = '0;
    end else if (i_rx_evt.wr_dword) begin
      s_d.rx_wr_lvl = s_q.rx_wr_lvl + 1'b1;
      s_d.rx_wr_ptr = rx_inc(s_q.rx_wr_ptr);
      s_d.rx_wr_cnt = s_q.rx_wr_cnt + 1'b1;
      if (i_rx_evt.wr_end) begin
        rx_wr_pkt     = s_q.rx_wr_cnt + 1'b1;
        s_d.rx_wr_cnt = '0;
        s_d.rx_wr_start = rx_inc(s_q.rx_wr_ptr);
      end
    end

    // Rx read side
    if (i_rx_evt.rd_rewind) begin
      s_d.rx_rd_lvl = s_q.rx_rd_lvl + s_q.rx_rd_cnt;
      s_d.rx_rd_ptr = s_q.rx_rd_start;
      s_d.rx_rd_cnt = '0;
    end else if (i_rx_evt.rd_dword) begin
      s_d.rx_rd_lvl = s_q.rx_rd_lvl - 1'b1;
      s_d.rx_rd_ptr = rx_inc(s_q.rx_rd_ptr);
      s_d.rx_rd_cnt = s_q.rx_rd_cnt + 1'b1;
      if (i_rx_evt.rd_end) begin
        rx_rd_pkt       = s_q.rx_rd_cnt + 1'b1;
        s_d.rx_rd_cnt   = '0;
        s_d.rx_rd_start = rx_inc(s_q.rx_rd_ptr);
      end
    end
    // Whole packet credits cross over between the two levels
    s_d.rx_rd_lvl = s_d.rx_rd_lvl + rx_wr_pkt;
    s_d.rx_wr_lvl = s_d.rx_wr_lvl - rx_rd_pkt;

    // Tx write side
    if (i_tx_evt.wr_rewind) begin
      s_d.tx_wr_lvl = s_q.tx_wr_lvl - s_q.tx_wr_cnt;
      s_d.tx_wr_ptr = s_q.tx_wr_start;
      s_d.tx_wr_cnt = '0;
    end else if (i_tx_evt.wr_dword) begin
      s_d.tx_wr_lvl = s_q.tx_wr_lvl + 1'b1;
      s_d.tx_wr_ptr = tx_inc(s_q.tx_wr_ptr);
      s_d.tx_wr_cnt = s_q.tx_wr_cnt + 1'b1;
      if (i_tx_evt.wr_end) begin
        tx_wr_pkt       = s_q.tx_wr_cnt + 1'b1;
        s_d.tx_wr_cnt   = '0;
        s_d.tx_wr_start = tx_inc(s_q.tx_wr_ptr);
      end
    end

    // Tx read side, rewind input ignored
    if (i_tx_evt.rd_dword) begin
      s_d.tx_rd_lvl = s_q.tx_rd_lvl - 1'b1;
      s_d.tx_rd_ptr = tx_inc(s_q.tx_rd_ptr);
      s_d.tx_rd_cnt = s_q.tx_rd_cnt + 1'b1;
      if (i_tx_evt.rd_end) begin
        tx_rd_pkt     = s_q.tx_rd_cnt + 1'b1;
        s_d.tx_rd_cnt = '0;
      end
    end
    s_d.tx_rd_lvl = s_d.tx_rd_lvl + tx_wr_pkt;
    s_d.tx_wr_lvl = s_d.tx_wr_lvl - tx_rd_pkt;

    // Short packet delay timer
    s_d.short_go = 1'b0;
    case (s_q.sp)
      SP_IDLE: begin
        s_d.sp_acc = '0;
        if (i_short_req) begin
          s_d.sp = SP_WAIT;
        end
      end
      SP_WAIT: begin
        s_d.sp_acc = s_q.sp_acc + 32'(TICKS_DEN);
        if (s_q.sp_acc >= 32'(s_q.delay) * 32'(TICKS_NUM)) begin
          s_d.sp       = SP_GO;
          s_d.short_go = 1'b1;
        end
      end
      SP_GO: begin
        if (!i_short_req) begin
          s_d.sp = SP_IDLE;
        end
      end
      default: begin
        s_d.sp = SP_IDLE;
      end
    endcase

    // APB slave, one wait state
    rd_cyc     = i_psel && i_penable && !s_q.pready;
    s_d.pready = rd_cyc;
    s_d.prdata = '0;
    if (rd_cyc) begin
      if (i_paddr == SHORT_PACKET_DELAY_ADDR) begin
        s_d.prdata = {16'h0000, s_q.delay};
      end else if (i_paddr == RX_FIFO_LEVEL_DEBUG_ADDR) begin
        s_d.prdata = {2'h0, s_q.rx_rd_lvl, 2'h0, s_q.rx_wr_lvl};
      end else if (i_paddr == RX_FIFO_POINTER_DEBUG_ADDR) begin
        s_d.prdata = {3'h0, s_q.rx_rd_ptr, 3'h0, s_q.rx_wr_ptr};
      end else if (i_paddr == TX_FIFO_LEVEL_DEBUG_ADDR) begin
        s_d.prdata = {4'h0, s_q.tx_rd_lvl, 4'h0, s_q.tx_wr_lvl};
      end else begin
        s_d.prdata = '0;
      end
    end

    // Write lands at the edge where the answer is seen
    if (i_psel && i_penable && s_q.pready && i_pwrite) begin
      if (i_paddr == SHORT_PACKET_DELAY_ADDR) begin
        s_d.delay = i_pwdata[DELAY_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q       <= '0;
      s_q.delay <= DELAY_RESET;
      s_q.sp    <= SP_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state, slave error tied low
  assign o_prdata  = s_q.prdata;
  assign o_pready  = s_q.pready;
  assign o_pslverr = 1'b0;
  assign o_short_go = s_q.short_go;

endmodule : packet_fifo_level_tracking

// File: src/pkt_fifo_pkg.sv
package pkt_fifo_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] SHORT_PACKET_DELAY_ADDR    = 12'h06c;
  localparam logic [11:0] RX_FIFO_LEVEL_DEBUG_ADDR   = 12'h070;
  localparam logic [11:0] RX_FIFO_POINTER_DEBUG_ADDR = 12'h074;
  localparam logic [11:0] TX_FIFO_LEVEL_DEBUG_ADDR   = 12'h078;
  localparam int          ADDR_W                     = 12;

  // ****************************************************************
  // Reset values and field widths
  // ****************************************************************
  localparam logic [15:0] DELAY_RESET   = 16'h0800;
  localparam int          DELAY_W       = 16;
  localparam int          RX_LVL_W      = 14;
  localparam int          TX_LVL_W      = 12;
  localparam int          RX_PTR_W      = 13;
  localparam int          TX_PTR_W      = 11;
  localparam int          HI_LSB        = 16;

  // ****************************************************************
  // Timing: one delay unit in picoseconds, clock period in picoseconds
  // ****************************************************************
  localparam int          DELAY_UNIT_PS = 16667;
  localparam int          CLK_PERIOD_PS = 100000;

  // ****************************************************************
  // Short packet wait states
  // ****************************************************************
  typedef enum logic [1:0] {
    SP_IDLE,
    SP_WAIT,
    SP_GO
  } sp_state_t;

  // ****************************************************************
  // Per-side event strobes
  // ****************************************************************
  typedef struct packed {
    logic wr_dword;   // One DWORD written
    logic wr_end;     // Last DWORD of packet written
    logic wr_rewind;  // Drop the partial write packet
    logic rd_dword;   // One DWORD read
    logic rd_end;     // Last DWORD of packet read
    logic rd_rewind;  // Restore read packet (rx only)
  } fifo_evt_t;

endpackage : pkt_fifo_pkg

// File: verification/packet_fifo_level_tracking_properties.sv
`timescale 1ns/1ps
module pkt_fifo_checks
  import pkt_fifo_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire fifo_evt_t   i_rx_evt,
  input wire fifo_evt_t   i_tx_evt,
  input wire logic        i_short_req,
  input wire logic        o_short_go
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // ****************************************************************
  // Bus answer
  // ****************************************************************
  sequence take_s;
    i_psel && i_penable && !o_pready;
  endsequence
  ready_after_take_a: assert property (take_s |=> o_pready)
    else $error("no answer one cycle after take");
  ready_single_a: assert property (o_pready |=> !o_pready)
    else $error("answer longer than one cycle");
  ready_cause_a: assert property (o_pready |-> $past(i_psel && i_penable))
    else $error("answer without request");
  prdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside answer");
  error_low_a: assert property (!o_pslverr)
    else $error("error response raised");
  lvl_reserved_a: assert property (
    o_pready && $past(i_paddr) == RX_FIFO_LEVEL_DEBUG_ADDR
    |-> o_prdata[31:30] == 2'h0 && o_prdata[15:14] == 2'h0)
    else $error("reserved level bits set");
  delay_upper_a: assert property (
    o_pready && $past(i_paddr) == SHORT_PACKET_DELAY_ADDR
    |-> o_prdata[31:16] == 16'h0)
    else $error("reserved delay bits set");
  // ****************************************************************
  // Short packet release
  // ****************************************************************
  go_single_a: assert property (o_short_go |=> !o_short_go)
    else $error("release longer than one cycle");
  go_wait_a: assert property ($rose(i_short_req) |=> !o_short_go [*2])
    else $error("release without wait");
endmodule : pkt_fifo_checks

bind packet_fifo_level_tracking pkt_fifo_checks i_pkt_fifo_checks (.*);

// File: verification/pkt_source.sv
`timescale 1ns/1ps
module pkt_source
  import pkt_fifo_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_short_go,
  output fifo_evt_t o_rx_evt,
  output fifo_evt_t o_tx_evt,
  output logic      o_short_req
);
  initial begin
    o_rx_evt = '0;
    o_tx_evt = '0;
    o_short_req = 1'h0;
  end
  // One strobe set on one side at the next edge, held until the next put
  task automatic put(input bit tx, input fifo_evt_t e);
    @(posedge i_clk);
    if (tx) o_tx_evt <= e;
    else o_rx_evt <= e;
  endtask : put
  // Packet of len DWORDs, closed by end marker or by rewind
  task automatic send(input bit tx, input bit rd, input bit rew, input int len);
    fifo_evt_t e;
    for (int k = 1; k <= len; k++) begin
      e = '0;
      e.rd_dword = rd;
      e.rd_end = rd && k == len && !rew;
      e.wr_dword = !rd;
      e.wr_end = !rd && k == len && !rew;
      put(tx, e);
    end
    e = '0;
    e.rd_rewind = rew && rd;
    e.wr_rewind = rew && !rd;
    if (rew) put(tx, e);
    put(tx, '0);
  endtask : send
  // Request held until release, dropped after; n counts cycles
  task automatic short_pkt(output int n);
    n = 0;
    @(posedge i_clk);
    o_short_req <= 1'h1;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_short_go !== 1'h1);
    o_short_req <= 1'h0;
  endtask : short_pkt
endmodule : pkt_source

// File: verification/packet_fifo_level_tracking_tb.sv
`timescale 1ns/1ps
module packet_fifo_level_tracking_tb
  import pkt_fifo_pkg::*;
;
  typedef struct {bit tx, rd, rew; int len; logic [31:0] rl, rp, tl;} row_t;
  logic        i_clk, i_nrst, psel, penable, pwrite, pready, short_req, short_go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  fifo_evt_t   rx_evt, tx_evt;
  int          fail_count, total_checks, n;
  row_t rows[10] = '{
    '{0, 0, 0, 5, 32'h0005_0005, 32'h0000_0005, 32'h0},
    '{0, 0, 1, 3, 32'h0005_0005, 32'h0000_0005, 32'h0},
    '{0, 1, 1, 2, 32'h0005_0005, 32'h0000_0005, 32'h0},
    '{0, 1, 0, 5, 32'h0, 32'h0005_0005, 32'h0},
    '{0, 0, 0, 14, 32'h000e_000e, 32'h0005_0003, 32'h0},
    '{1, 0, 0, 4, 32'h000e_000e, 32'h0005_0003, 32'h0004_0004},
    '{1, 0, 1, 2, 32'h000e_000e, 32'h0005_0003, 32'h0004_0004},
    '{1, 1, 0, 4, 32'h000e_000e, 32'h0005_0003, 32'h0},
    '{1, 0, 0, 3, 32'h000e_000e, 32'h0005_0003, 32'h0003_0003},
    '{1, 1, 1, 2, 32'h000e_000e, 32'h0005_0003, 32'h0001_0003}};
  packet_fifo_level_tracking #(.RX_DEPTH(16), .TX_DEPTH(16)) i_packet_fifo_level_tracking (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(), .i_rx_evt(rx_evt), .i_tx_evt(tx_evt),
    .i_short_req(short_req), .o_short_go(short_go));
  pkt_source i_pkt_source (.i_clk(i_clk), .i_short_go(short_go), .o_rx_evt(rx_evt),
    .o_tx_evt(tx_evt), .o_short_req(short_req));
  initial begin
    i_clk = 1'h0;
    forever #50 i_clk = ~i_clk;
  end
  // Setup, access, hold until answer, release after that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge i_clk);
    penable <= 1'h1;
    do @(posedge i_clk); while (pready !== 1'h1);
    r = prdata;
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic in_range(input int v, input int lo, input int hi);
    total_checks++;
    if (v < lo || v > hi) begin
      fail_count++;
      $display("[ERR] %0t wait %0d cycles", $time, v);
    end
  endtask : in_range
  task automatic tally_and_finish;
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    {i_nrst, psel, penable, pwrite, paddr, pwdata, fail_count, total_checks} = '0;
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'h1;
    for (int a = 0; a < 4; a++) begin
      apb(1'h0, 12'(12'h06c + 4 * a), 32'h0);
      cmp(r, a == 0 ? 32'h800 : 32'h0);
    end
    i_pkt_source.short_pkt(n);
    in_range(n, 342, 350);
    apb(1'h1, SHORT_PACKET_DELAY_ADDR, 32'hffff_003c);
    apb(1'h0, SHORT_PACKET_DELAY_ADDR, 32'h0);
    cmp(r, 32'h3c);
    i_pkt_source.short_pkt(n);
    in_range(n, 11, 16);
    foreach (rows[i]) begin
      i_pkt_source.send(rows[i].tx, rows[i].rd, rows[i].rew, rows[i].len);
      apb(1'h0, RX_FIFO_LEVEL_DEBUG_ADDR, 32'h0);
      cmp(r, rows[i].rl);
      apb(1'h0, RX_FIFO_POINTER_DEBUG_ADDR, 32'h0);
      cmp(r, rows[i].rp);
      apb(1'h0, TX_FIFO_LEVEL_DEBUG_ADDR, 32'h0);
      cmp(r, rows[i].tl);
    end
    apb(1'h1, RX_FIFO_LEVEL_DEBUG_ADDR, 32'hffff_ffff);
    apb(1'h0, RX_FIFO_LEVEL_DEBUG_ADDR, 32'h0);
    cmp(r, 32'h000e_000e);
    apb(1'h0, 12'h080, 32'h0);
    cmp(r, 32'h0);
    i_nrst <= 1'h0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'h1;
    apb(1'h0, RX_FIFO_POINTER_DEBUG_ADDR, 32'h0);
    cmp(r, 32'h0);
    tally_and_finish();
  end
endmodule : packet_fifo_level_tracking_tb
